// ===== verilog/dual_timer_regs.vh
// register offsets, field positions, reset values and timing counts of the dual timer front end
// included by the timer design files; definitions only
`ifndef DUAL_TIMER_REGS_VH
`define DUAL_TIMER_REGS_VH
`define ADDR_W 8
`define OFS_MODE_CTRL 8'h89
`define OFS_RUN_CTRL 8'h88
`define OFS_CNT0_LOW 8'h8a
`define OFS_CNT1_LOW 8'h8b
`define OFS_CNT0_HIGH 8'h8c
`define OFS_CNT1_HIGH 8'h8d
`define OFS_IRQ_STATUS 8'h8e
`define OFS_IRQ_MASK 8'h8f
`define RST_MODE_CTRL 8'h00
`define RST_BYTE 8'h00
`define MODE0_GATE 3
`define MODE0_CSEL 2
`define MODE0_MODE_HI 1
`define MODE0_MODE_LO 0
`define MODE1_GATE 7
`define MODE1_CSEL 6
`define MODE1_MODE_HI 5
`define MODE1_MODE_LO 4
`define RUN0_BIT 4
`define RUN1_BIT 6
`define FLAG0_BIT 5
`define FLAG1_BIT 7
`define IRQ0_BIT 0
`define IRQ1_BIT 1
`define OSC_PER_MCYCLE 6
`define MODE_13BIT 2'h0
`define MODE_16BIT 2'h1
`define MODE_RELOAD 2'h2
`define MODE_SPLIT 2'h3
`endif

// ===== verilog/count_unit.v
// one 16-bit count unit: mode 0..3 counting, overflow pulse, byte writes
// assumes a one-cycle count step already gated and synchronised by the parent
`timescale 1ns/100ps
`include "dual_timer_regs.vh"
module count_unit #(
	parameter W = 8
) (
	input wire clk,
	input wire rstn,
	input wire step,
	input wire stepHigh,
	input wire [1:0] mode,
	input wire wrLow,
	input wire wrHigh,
	input wire [W-1:0] wrData,
	output reg [W-1:0] lowByte_q,
	output reg [W-1:0] highByte_q,
	output reg ovf,
	output reg ovfHigh
);
	reg [W-1:0] lowByte_d;
	reg [W-1:0] highByte_d;
	reg [2*W:0] sum;
	always @* begin
		lowByte_d = lowByte_q;
		highByte_d = highByte_q;
		ovf = 1'b0;
		ovfHigh = 1'b0;
		sum = {(2*W+1){1'b0}};
		if (step) begin
			case (mode)
				`MODE_13BIT: begin
					// upper three low bits are left as they were
					sum = {1'b0, highByte_q, 3'b000, lowByte_q[4:0]} + {{(2*W){1'b0}}, 1'b1};
					if (lowByte_q[4:0] == 5'h1f) begin
						sum = {1'b0, highByte_q, {W{1'b0}}} + {{W{1'b0}}, 1'b1, {W{1'b0}}};
					end
					lowByte_d = {lowByte_q[W-1:5], sum[4:0]};
					highByte_d = sum[2*W-1:W];
					ovf = sum[2*W];
				end
				`MODE_16BIT: begin
					sum = {1'b0, highByte_q, lowByte_q} + {{(2*W){1'b0}}, 1'b1};
					lowByte_d = sum[W-1:0];
					highByte_d = sum[2*W-1:W];
					ovf = sum[2*W];
				end
				`MODE_RELOAD: begin
					if (&lowByte_q) begin
						lowByte_d = highByte_q;
						ovf = 1'b1;
					end else begin
						lowByte_d = lowByte_q + {{(W-1){1'b0}}, 1'b1};
					end
				end
				default: begin
					// split mode: low byte counts alone
					lowByte_d = lowByte_q + {{(W-1){1'b0}}, 1'b1};
					ovf = &lowByte_q;
				end
			endcase
		end
		if (stepHigh && mode == `MODE_SPLIT) begin
			highByte_d = highByte_q + {{(W-1){1'b0}}, 1'b1};
			ovfHigh = &highByte_q;
		end
		if (wrLow) begin
			lowByte_d = wrData;
		end
		if (wrHigh) begin
			highByte_d = wrData;
		end
	end
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			lowByte_q <= {W{1'b0}};
			highByte_q <= {W{1'b0}};
		end else begin
			lowByte_q <= lowByte_d;
			highByte_q <= highByte_d;
		end
	end
endmodule

// ===== verilog/dual_timer.v
// dual 16-bit timer/counter front end with mode control, run control and interrupt registers
// assumes clk is the oscillator, register port on clk, count and gate pins asynchronous
// Operation
// - two independent 16-bit count units, each timer or counter
// - timer function advances once per machine cycle of six oscillator periods
// - counter function advances only on falling edge of its count pin
// - each count pin sampled exactly once per machine cycle
// - count when one sample is high and the next is low
// - incremented value visible in the machine cycle after detection
// - one external edge takes two machine cycles to recognise
// - select bit clear counts machine cycles, set counts the count pin
// - gate set: count only while gate pin high and run bit set
// - gate clear: count whenever run bit set
// - two-bit mode field per unit; mode 3 differs between units
// - mode control at 89h: unit1 gate,select,mode in 7:4, unit0 in 3:0
// - mode control not bit addressable, resets to zero
// - mode 0 counts 13 bits: high byte and low five low-byte bits
// - mode 1 counts all sixteen bits
// - mode 2 low byte reloads from high byte on overflow
// - rollover sets overflow flag; cleared by vectoring or software
`timescale 1ns/100ps
`include "dual_timer_regs.vh"
module dual_timer #(
	parameter MCYCLE = `OSC_PER_MCYCLE
) (
	input wire clk,
	input wire rstn,
	input wire [7:0] addr,
	input wire [7:0] wrData,
	input wire wrStb,
	input wire rdStb,
	output reg [7:0] rdData,
	input wire countPinZero,
	input wire countPinOne,
	input wire gatePinZero,
	input wire gatePinOne,
	input wire vectorAck0,
	input wire vectorAck1,
	output wire overflowFlag0,
	output wire overflowFlag1,
	output wire irq
);
	localparam ST_LOW = 2'b01;
	localparam ST_HIGH = 2'b10;

	function isWr;
		input [7:0] a;
		input [7:0] ofs;
		begin
			isWr = wrStb && (a == ofs);
		end
	endfunction

	reg [7:0] modeCtrl_q;
	reg [7:0] runCtrl_q;
	reg [1:0] irqStatus_q;
	reg [1:0] irqMask_q;
	reg [2:0] phase_q;
	reg [3:0] syncA_q;
	reg [3:0] syncB_q;
	reg [1:0] edgeSt0_q;
	reg [1:0] edgeSt1_q;
	reg [1:0] fall_q;
	wire mcycTick;
	wire [7:0] low0;
	wire [7:0] high0;
	wire [7:0] low1;
	wire [7:0] high1;
	wire ovf0;
	wire ovf1;
	wire ovfSplit;
	wire en0;
	wire en1;
	wire step0;
	wire step1;
	wire stepSplit;
	wire flagSet0;
	wire flagSet1;

	// machine cycle prescaler
	assign mcycTick = (phase_q == MCYCLE - 1);
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			phase_q <= 3'h0;
		end else if (mcycTick) begin
			phase_q <= 3'h0;
		end else begin
			phase_q <= phase_q + 3'h1;
		end
	end

	// synchronisers: first stage read only by the second
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			syncA_q <= 4'h0;
			syncB_q <= 4'h0;
		end else begin
			syncA_q <= {gatePinOne, gatePinZero, countPinOne, countPinZero};
			syncB_q <= syncA_q;
		end
	end

	// per machine cycle sampling and falling edge detection
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			edgeSt0_q <= ST_LOW;
			edgeSt1_q <= ST_LOW;
			fall_q <= 2'b00;
		end else if (mcycTick) begin
			// high in one sample, low in the next
			fall_q[0] <= edgeSt0_q == ST_HIGH && !syncB_q[0];
			fall_q[1] <= edgeSt1_q == ST_HIGH && !syncB_q[1];
			case (edgeSt0_q)
				ST_LOW: edgeSt0_q <= syncB_q[0] ? ST_HIGH : ST_LOW;
				ST_HIGH: edgeSt0_q <= syncB_q[0] ? ST_HIGH : ST_LOW;
				default: edgeSt0_q <= ST_LOW;
			endcase
			case (edgeSt1_q)
				ST_LOW: edgeSt1_q <= syncB_q[1] ? ST_HIGH : ST_LOW;
				ST_HIGH: edgeSt1_q <= syncB_q[1] ? ST_HIGH : ST_LOW;
				default: edgeSt1_q <= ST_LOW;
			endcase
		end
	end

	// gating: gate bit makes the gate pin matter, run bit always does
	assign en0 = runCtrl_q[`RUN0_BIT] && (!modeCtrl_q[`MODE0_GATE] || syncB_q[2]);
	assign en1 = runCtrl_q[`RUN1_BIT] && (!modeCtrl_q[`MODE1_GATE] || syncB_q[3]) &&
		(modeCtrl_q[`MODE1_MODE_HI:`MODE1_MODE_LO] != `MODE_SPLIT);
	// detected edge counted at the next machine cycle boundary, two cycles total
	assign step0 = en0 && mcycTick && (modeCtrl_q[`MODE0_CSEL] ? fall_q[0] : 1'b1);
	assign step1 = en1 && mcycTick && (modeCtrl_q[`MODE1_CSEL] ? fall_q[1] : 1'b1);
	// split mode: unit0 high byte is a timer run by the unit1 run bit
	assign stepSplit = mcycTick && runCtrl_q[`RUN1_BIT];

	count_unit #(.W(8)) unitZero (
		.clk(clk),
		.rstn(rstn),
		.step(step0),
		.stepHigh(stepSplit),
		.mode(modeCtrl_q[`MODE0_MODE_HI:`MODE0_MODE_LO]),
		.wrLow(isWr(addr, `OFS_CNT0_LOW)),
		.wrHigh(isWr(addr, `OFS_CNT0_HIGH)),
		.wrData(wrData),
		.lowByte_q(low0),
		.highByte_q(high0),
		.ovf(ovf0),
		.ovfHigh(ovfSplit)
	);
	count_unit #(.W(8)) unitOne (
		.clk(clk),
		.rstn(rstn),
		.step(step1),
		.stepHigh(1'b0),
		.mode(modeCtrl_q[`MODE1_MODE_HI:`MODE1_MODE_LO]),
		.wrLow(isWr(addr, `OFS_CNT1_LOW)),
		.wrHigh(isWr(addr, `OFS_CNT1_HIGH)),
		.wrData(wrData),
		.lowByte_q(low1),
		.highByte_q(high1),
		.ovf(ovf1),
		.ovfHigh()
	);

	// in split mode the unit0 high byte overflow takes over flag 1
	assign flagSet0 = ovf0;
	assign flagSet1 = (modeCtrl_q[`MODE0_MODE_HI:`MODE0_MODE_LO] == `MODE_SPLIT) ? ovfSplit : ovf1;

	// control registers; a hardware set wins over any clear
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			modeCtrl_q <= `RST_MODE_CTRL;
			runCtrl_q <= `RST_BYTE;
			irqStatus_q <= 2'b00;
			irqMask_q <= 2'b00;
		end else begin
			if (isWr(addr, `OFS_MODE_CTRL)) begin
				modeCtrl_q <= wrData;
			end
			if (isWr(addr, `OFS_RUN_CTRL)) begin
				runCtrl_q[`RUN0_BIT] <= wrData[`RUN0_BIT];
				runCtrl_q[`RUN1_BIT] <= wrData[`RUN1_BIT];
				runCtrl_q[`FLAG0_BIT] <= wrData[`FLAG0_BIT];
				runCtrl_q[`FLAG1_BIT] <= wrData[`FLAG1_BIT];
			end else begin
				if (vectorAck0) begin
					runCtrl_q[`FLAG0_BIT] <= 1'b0;
				end
				if (vectorAck1) begin
					runCtrl_q[`FLAG1_BIT] <= 1'b0;
				end
			end
			if (flagSet0) begin
				runCtrl_q[`FLAG0_BIT] <= 1'b1;
			end
			if (flagSet1) begin
				runCtrl_q[`FLAG1_BIT] <= 1'b1;
			end
			if (isWr(addr, `OFS_IRQ_MASK)) begin
				irqMask_q <= wrData[1:0];
			end
			irqStatus_q <= (irqStatus_q & ~(isWr(addr, `OFS_IRQ_STATUS) ? wrData[1:0] : 2'b00)) |
				{flagSet1, flagSet0};
		end
	end

	assign overflowFlag0 = runCtrl_q[`FLAG0_BIT];
	assign overflowFlag1 = runCtrl_q[`FLAG1_BIT];
	assign irq = |(irqStatus_q & irqMask_q);

	// read data valid the cycle after the strobe only
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdData <= 8'h00;
		end else if (rdStb) begin
			case (addr)
				`OFS_MODE_CTRL: rdData <= modeCtrl_q;
				`OFS_RUN_CTRL: rdData <= runCtrl_q & 8'hf0;
				`OFS_CNT0_LOW: rdData <= low0;
				`OFS_CNT1_LOW: rdData <= low1;
				`OFS_CNT0_HIGH: rdData <= high0;
				`OFS_CNT1_HIGH: rdData <= high1;
				`OFS_IRQ_STATUS: rdData <= {6'h00, irqStatus_q};
				`OFS_IRQ_MASK: rdData <= {6'h00, irqMask_q};
				default: rdData <= 8'h00;
			endcase
		end else begin
			rdData <= 8'h00;
		end
	end
endmodule

// ===== bench/dual_timer_props.sv
// port checker for the dual timer front end
// assumes a bind from the bench top file
`timescale 1ns/100ps
module dual_timer_props (
	input wire clk,
	input wire rstn,
	input wire [7:0] addr,
	input wire [7:0] wrData,
	input wire wrStb,
	input wire rdStb,
	input wire [7:0] rdData,
	input wire countPinZero,
	input wire gatePinZero,
	input wire vectorAck0,
	input wire vectorAck1,
	input wire overflowFlag0,
	input wire overflowFlag1,
	input wire irq
);
	logic [7:0] modeQ;
	logic run0Q, pinQ;
	logic [1:0] maskQ;
	logic [4:0] blockCnt, pinCnt;
	wire w88 = wrStb && addr == 8'h88;
	// shadows of the control registers; counts run long enough to drain the pin pipeline
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			modeQ <= 8'h00;
			run0Q <= 1'h0;
			maskQ <= 2'h0;
			pinQ <= 1'h0;
			blockCnt <= 5'h00;
			pinCnt <= 5'h00;
		end else begin
			if (wrStb && addr == 8'h89)
				modeQ <= wrData;
			if (w88)
				run0Q <= wrData[4];
			if (wrStb && addr == 8'h8f)
				maskQ <= wrData[1:0];
			pinQ <= countPinZero;
			blockCnt <= (!run0Q || modeQ[3] && !gatePinZero) ? blockCnt + 5'(blockCnt != 5'h1f) : 5'h00;
			pinCnt <= (modeQ[2] && pinQ == countPinZero) ? pinCnt + 5'(pinCnt != 5'h1f) : 5'h00;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_rd_idle: assert property (!$past(rdStb) |-> rdData == 8'h00) else $error("read data outside slot");
	a_mode_readback: assert property (
		wrStb && addr == 8'h89 ##1 rdStb && addr == 8'h89 |=> rdData == $past(wrData, 2))
		else $error("mode readback wrong");
	a_flag0_hold: assert property (
		overflowFlag0 && !vectorAck0 && !w88 |=> overflowFlag0) else $error("flag 0 lost");
	a_flag1_hold: assert property (
		overflowFlag1 && !vectorAck1 && !w88 |=> overflowFlag1) else $error("flag 1 lost");
	a_ack_clear: assert property (
		vectorAck0 && !w88 && blockCnt >= 24 |=> !overflowFlag0) else $error("ack did not clear");
	a_stop_noflag: assert property (
		blockCnt >= 24 && !w88 |=> !$rose(overflowFlag0)) else $error("count while disabled");
	a_pin_still: assert property (
		pinCnt >= 24 && !w88 |=> !$rose(overflowFlag0)) else $error("count on quiet pin");
	a_irq_masked: assert property (maskQ == 2'h0 |-> !irq) else $error("irq while masked");
endmodule

// ===== bench/pin_source.sv
// pulse train source standing in for an external count pin
// assumes start is a one-cycle request while busy is low
`timescale 1ns/100ps
module pin_source #(
	parameter HOLD = 12
) (
	input wire logic clk,
	input wire logic start,
	input wire logic [7:0] edges,
	output logic pin = 1'h1,
	output logic busy = 1'h0
);
	always @(posedge clk) if (start) begin
		busy <= 1'h1;
		repeat (edges) begin
			repeat (HOLD) @(posedge clk);
			pin <= 1'h0;
			repeat (HOLD) @(posedge clk);
			pin <= 1'h1;
		end
		busy <= 1'h0;
	end
endmodule

// ===== bench/dual_timer_tb.sv
// self-checking bench for the dual timer front end
// assumes pin_source partners on both count pins
`timescale 1ns/100ps
module dual_timer_tb;
	logic clk = 1'h0, rstn = 1'h0, wrStb = 1'h0, rdStb = 1'h0, rdLate = 1'h0, start = 1'h0;
	logic gatePinZero = 1'h1, gatePinOne = 1'h0, vectorAck0 = 1'h0, vectorAck1 = 1'h0;
	logic [7:0] addr = 8'h00, wrData = 8'h00, n0 = 8'h00, n1 = 8'h00, m, v, rdData;
	logic countPinZero, countPinOne, busy0, busy1, overflowFlag0, overflowFlag1, irq;
	logic [7:0] expQ[$], mskQ[$];
	logic [7:0] regA[6] = '{8'h89, 8'h88, 8'h8a, 8'h8c, 8'h8e, 8'h8f};
	logic [7:0] loT[3] = '{8'h18, 8'hf8, 8'hf8}, hiT[3] = '{8'hff, 8'hff, 8'h80};
	logic [7:0] hiX[3] = '{8'h00, 8'h00, 8'h80}, loM[3] = '{8'h1e, 8'hfe, 8'hfe};
	int failCount = 0, checked = 0, n, i;
	always #20 clk = ~clk;
	dual_timer #(.MCYCLE(6)) DUT (.clk(clk), .rstn(rstn), .addr(addr), .wrData(wrData), .wrStb(wrStb),
		.rdStb(rdStb), .rdData(rdData), .countPinZero(countPinZero), .countPinOne(countPinOne),
		.gatePinZero(gatePinZero), .gatePinOne(gatePinOne), .vectorAck0(vectorAck0),
		.vectorAck1(vectorAck1), .overflowFlag0(overflowFlag0), .overflowFlag1(overflowFlag1), .irq(irq));
	pin_source src0 (.clk(clk), .start(start), .edges(n0), .pin(countPinZero), .busy(busy0));
	// fastest legal source: one machine cycle per level
	pin_source #(.HOLD(6)) src1 (.clk(clk), .start(start), .edges(n1), .pin(countPinOne), .busy(busy1));
	task chk(input string what, input logic [7:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			failCount++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task bus(input logic w, r, input logic [7:0] a, d);
		@(posedge clk);
		wrStb <= w;
		rdStb <= r;
		addr <= a;
		wrData <= d;
	endtask
	task wr(input logic [7:0] a, d);
		bus(1'h1, 1'h0, a, d);
	endtask
	task rd(input logic [7:0] a, e, mk);
		expQ.push_back(e);
		mskQ.push_back(mk);
		bus(1'h0, 1'h1, a, 8'h00);
	endtask
	task tick(input int c);
		repeat (c) bus(1'h0, 1'h0, 8'h00, 8'h00);
	endtask
	task ack(input logic u);
		@(posedge clk);
		vectorAck0 <= !u;
		vectorAck1 <= u;
		@(posedge clk);
		vectorAck0 <= 1'h0;
		vectorAck1 <= 1'h0;
	endtask
	task pulse(input logic [7:0] a, b);
		n0 <= a;
		n1 <= b;
		start <= 1'h1;
		tick(1);
		start <= 1'h0;
		n = 0;
		do begin
			tick(1);
			#1 n++;
		end while ((busy0 || busy1) && n < 600);
		tick(30);
	endtask
	task endSim;
		$display("compares %0d mismatches %0d", checked, failCount);
		if (failCount == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk) rdLate <= rdStb;
	always @(negedge clk) if (rdLate) begin
		m = mskQ.pop_front();
		chk("read data", rdData & m, expQ.pop_front() & m);
	end
	initial begin
		repeat (20000) @(posedge clk);
		failCount++;
		endSim;
	end
	initial begin
		void'($urandom(32'h163b4dee));
		repeat (12) @(posedge clk);
		rstn <= 1'h1;
		foreach (regA[k]) rd(regA[k], 8'h00, 8'hff);
		v = 8'($urandom);
		wr(8'h89, v);
		rd(8'h89, v, 8'hff);
		wr(8'h80, 8'h5a);
		rd(8'h80, 8'h00, 8'hff);
		wr(8'h88, 8'ha0);
		tick(2);
		#1 chk("flag one set", overflowFlag1, 8'h01);
		ack(1'h1);
		tick(1);
		#1 chk("flag one acked", overflowFlag1, 8'h00);
		$display("test registers done");
		wr(8'h89, 8'h55);
		wr(8'h88, 8'h50);
		v = 8'($urandom_range(5, 1));
		pulse(v, 8'h03);
		wr(8'h88, 8'h00);
		rd(8'h8a, v, 8'hff);
		rd(8'h8b, 8'h03, 8'hff);
		rd(8'h8c, 8'h00, 8'hff);
		$display("test counter done");
		wr(8'h8a, 8'h00);
		// both units gated counters; unit1 keeps its count of three
		wr(8'h89, 8'hdd);
		wr(8'h88, 8'h50);
		gatePinZero <= 1'h0;
		pulse(8'h03, 8'h01);
		rd(8'h8a, 8'h00, 8'hff);
		rd(8'h8b, 8'h03, 8'hff);
		gatePinZero <= 1'h1;
		gatePinOne <= 1'h1;
		pulse(8'h02, 8'h01);
		rd(8'h8a, 8'h02, 8'hff);
		rd(8'h8b, 8'h04, 8'hff);
		wr(8'h89, 8'h55);
		gatePinZero <= 1'h0;
		gatePinOne <= 1'h0;
		pulse(8'h02, 8'h01);
		rd(8'h8a, 8'h04, 8'hff);
		rd(8'h8b, 8'h05, 8'hff);
		wr(8'h88, 8'h00);
		$display("test gating done");
		wr(8'h8f, 8'h01);
		for (i = 0; i < 3; i++) begin
			wr(8'h89, 8'(i));
			wr(8'h8c, hiT[i]);
			wr(8'h8a, loT[i]);
			wr(8'h88, 8'h10);
			n = 0;
			do begin
				tick(1);
				#1 n++;
			end while (overflowFlag0 !== 1'h1 && n < 200);
			// stop at once, keeping the flag, so at most one extra count lands
			wr(8'h88, 8'h20);
			chk("overflow delay", 8'(n >= 40 && n <= 56), 8'h01);
			#1 chk("irq raised", irq, 8'h01);
			rd(8'h8c, hiX[i], 8'hff);
			rd(8'h8a, hiX[i], loM[i]);
			rd(8'h8e, 8'h01, 8'hff);
			wr(8'h8e, 8'h01);
			tick(30);
			#1 chk("irq cleared", irq, 8'h00);
			ack(1'h0);
			tick(1);
			#1 chk("flag zero acked", overflowFlag0, 8'h00);
		end
		$display("test timer modes done");
		// split mode: unit0 high byte times on run1 and owns flag1, unit1 stopped
		wr(8'h89, 8'h33);
		wr(8'h8c, 8'hf8);
		wr(8'h8a, 8'h00);
		wr(8'h88, 8'h40);
		n = 0;
		do begin
			tick(1);
			#1 n++;
		end while (overflowFlag1 !== 1'h1 && n < 200);
		wr(8'h88, 8'h80);
		#1 chk("split overflow delay", 8'(n >= 40 && n <= 56), 8'h01);
		chk("split irq masked", irq, 8'h00);
		rd(8'h8c, 8'h00, 8'hfe);
		rd(8'h8a, 8'h00, 8'hff);
		rd(8'h8b, 8'h05, 8'hff);
		rd(8'h8e, 8'h02, 8'hff);
		wr(8'h8f, 8'h02);
		tick(1);
		#1 chk("split irq raised", irq, 8'h01);
		$display("test split mode done");
		tick(4);
		endSim;
	end
endmodule
bind dual_timer dual_timer_props props (.clk(clk), .rstn(rstn), .addr(addr), .wrData(wrData), .wrStb(wrStb),
	.rdStb(rdStb), .rdData(rdData), .countPinZero(countPinZero), .gatePinZero(gatePinZero),
	.vectorAck0(vectorAck0), .vectorAck1(vectorAck1), .overflowFlag0(overflowFlag0),
	.overflowFlag1(overflowFlag1), .irq(irq));
